// *** status_decoder_params.svh ***
// Constants for the status-decoding command generator
`ifndef STATUS_DECODER_PARAMS_SVH
`define STATUS_DECODER_PARAMS_SVH

// Status codes, bit 2 first, as driven on the active-low status pins
`define STATUS_IRQ_ACK 3'h0
`define STATUS_IO_READ 3'h1
`define STATUS_IO_WRITE 3'h2
`define STATUS_HALT 3'h3
`define STATUS_CODE_FETCH 3'h4
`define STATUS_MEM_READ 3'h5
`define STATUS_MEM_WRITE 3'h6
`define STATUS_PASSIVE 3'h7

// Clock and grant-to-command timing
`define CLK_PERIOD_NS 20
`define GRANT_ENABLE_MIN_NS 110
`define GRANT_ENABLE_MAX_NS 250
`define GRANT_ENABLE_MIN_CYC \
    ((`GRANT_ENABLE_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define GRANT_ENABLE_MAX_CYC (`GRANT_ENABLE_MAX_NS / `CLK_PERIOD_NS)

// Synchroniser depth and what is left for the grant counter
`define SYNC_STAGES 2
`define GRANT_COUNT_CYC (`GRANT_ENABLE_MIN_CYC - `SYNC_STAGES)
`define GRANT_COUNT_WIDTH 4

// Reset and idle levels
`define CMD_IDLE 1'b1
`define DIR_IDLE 1'b1
`define OE_OFF 1'b1

`endif

// *** status_decoder_pkg.sv ***
// Types for the status-decoding command generator
package status_decoder_pkg;

    typedef enum logic [2:0] {
        st_idle,
        st_strobe,
        st_lead,
        st_write,
        st_hold
    } cycle_state_t;

    typedef logic [2:0] status_code_t;

endpackage

// *** sync_stage.sv ***
// Two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
module sync_stage #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta;

    // First stage feeds only the second stage
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            meta <= RESET_VALUE;
            sync_out <= RESET_VALUE;
        end else begin
            meta <= pin_in;
            sync_out <= meta;
        end
    end

endmodule

// *** grant_delay.sv ***
// Counts the settle time between bus grant and command enable
`include "status_decoder_params.svh"
`timescale 1ns/1ps
module grant_delay (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic grant_active,
    output logic grant_ready
);

    logic [`GRANT_COUNT_WIDTH-1:0] count;
    logic [`GRANT_COUNT_WIDTH-1:0] next_count;
    logic next_grant_ready;

    localparam logic [`GRANT_COUNT_WIDTH-1:0] LAST =
        `GRANT_COUNT_WIDTH'(`GRANT_COUNT_CYC - 1);

    // Loss of grant clears at once so the next grant waits in full
    always_comb begin
        next_count = count;
        next_grant_ready = 1'b0;
        if (!grant_active) begin
            next_count = '0;
        end else if (count < LAST) begin
            next_count = count + `GRANT_COUNT_WIDTH'(1);
        end else begin
            next_grant_ready = 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            count <= '0;
            grant_ready <= 1'b0;
        end else begin
            count <= next_count;
            grant_ready <= next_grant_ready;
        end
    end

endmodule

// *** status_command_generator.sv ***
// Status-line decoder driving bus commands and transceiver controls
`include "status_decoder_params.svh"
`timescale 1ns/1ps
module status_command_generator (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic cycle_status_bit0_n,
    input wire logic cycle_status_bit1_n,
    input wire logic cycle_status_bit2_n,
    input wire logic bus_grant_n,
    input wire logic command_qualifier,
    input wire logic bus_mode_strap,
    output logic address_strobe,
    output logic data_enable,
    output logic xfer_direction,
    output logic cascade_or_periph_enable,
    output logic early_io_write_n,
    output logic io_write_n,
    output logic io_read_n,
    output logic early_mem_write_n,
    output logic mem_write_n,
    output logic mem_read_n,
    output logic irq_ack_n,
    output logic mem_cmd_oe_n,
    output logic io_cmd_oe_n
);

    // Synchronised pins
    status_decoder_pkg::status_code_t status_sync;
    logic grant_n_sync;
    logic qualifier_sync;
    logic strap_sync;
    logic grant_ready;

    sync_stage #(
        .WIDTH(3),
        .RESET_VALUE(`STATUS_PASSIVE)
    ) u_status_sync (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .pin_in({cycle_status_bit2_n, cycle_status_bit1_n,
                 cycle_status_bit0_n}),
        .sync_out(status_sync)
    );

    // Grant idles released, qualifier idles low, strap idles system mode
    sync_stage #(
        .WIDTH(3),
        .RESET_VALUE(3'h4)
    ) u_ctrl_sync (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .pin_in({bus_grant_n, command_qualifier, bus_mode_strap}),
        .sync_out({grant_n_sync, qualifier_sync, strap_sync})
    );

    grant_delay u_grant_delay (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .grant_active(!grant_n_sync),
        .grant_ready(grant_ready)
    );

    // Cycle sequencer state
    status_decoder_pkg::cycle_state_t state;
    status_decoder_pkg::cycle_state_t next_state;
    status_decoder_pkg::status_code_t code;
    status_decoder_pkg::status_code_t next_code;
    logic io_mode;
    logic next_io_mode;
    logic passive;

    assign passive = (status_sync == `STATUS_PASSIVE);

    // Mode follows the strap; it is static on a real board
    always_comb begin
        next_io_mode = strap_sync;
    end

    always_comb begin
        next_state = state;
        next_code = code;
        case (state)
            status_decoder_pkg::st_idle: begin
                if (!passive) begin
                    // Code held for the whole cycle, halt included
                    next_code = status_sync;
                    next_state = status_decoder_pkg::st_strobe;
                end
            end
            status_decoder_pkg::st_strobe: begin
                if (passive) begin
                    next_state = status_decoder_pkg::st_idle;
                end else begin
                    next_state = status_decoder_pkg::st_lead;
                end
            end
            status_decoder_pkg::st_lead: begin
                if (passive) begin
                    next_state = status_decoder_pkg::st_idle;
                end else begin
                    next_state = status_decoder_pkg::st_write;
                end
            end
            status_decoder_pkg::st_write: begin
                if (passive) begin
                    next_state = status_decoder_pkg::st_idle;
                end else begin
                    next_state = status_decoder_pkg::st_hold;
                end
            end
            status_decoder_pkg::st_hold: begin
                if (passive) begin
                    next_state = status_decoder_pkg::st_idle;
                end
            end
            default: begin
                next_state = status_decoder_pkg::st_idle;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            state <= status_decoder_pkg::st_idle;
            code <= `STATUS_PASSIVE;
            io_mode <= 1'b0;
        end else begin
            state <= next_state;
            code <= next_code;
            io_mode <= next_io_mode;
        end
    end

    // Decode of the coming cycle
    logic strobe_phase;
    logic cmd_phase;
    logic write_phase;
    logic is_irq_ack;
    logic is_io_read;
    logic is_io_write;
    logic is_mem_read;
    logic is_mem_write;
    logic is_read_kind;
    logic is_io_kind;
    logic grant_on;
    logic mem_ok;
    logic io_ok;

    always_comb begin
        strobe_phase = (next_state == status_decoder_pkg::st_strobe);
        cmd_phase = (next_state == status_decoder_pkg::st_lead) ||
                    (next_state == status_decoder_pkg::st_write) ||
                    (next_state == status_decoder_pkg::st_hold);
        // Plain write waits one clock behind the early write
        write_phase = (next_state == status_decoder_pkg::st_write) ||
                      (next_state == status_decoder_pkg::st_hold);
    end

    // Decode table of the code held for this cycle
    always_comb begin
        is_irq_ack = 1'b0;
        is_io_read = 1'b0;
        is_io_write = 1'b0;
        is_mem_read = 1'b0;
        is_mem_write = 1'b0;
        case (next_code)
            `STATUS_IRQ_ACK: begin
                is_irq_ack = 1'b1;
            end
            `STATUS_IO_READ: begin
                is_io_read = 1'b1;
            end
            `STATUS_IO_WRITE: begin
                is_io_write = 1'b1;
            end
            `STATUS_CODE_FETCH: begin
                is_mem_read = 1'b1;
            end
            `STATUS_MEM_READ: begin
                is_mem_read = 1'b1;
            end
            `STATUS_MEM_WRITE: begin
                is_mem_write = 1'b1;
            end
            default: begin
                // Halt and passive give no command
                is_mem_read = 1'b0;
            end
        endcase
        is_read_kind = is_irq_ack || is_io_read || is_mem_read;
        is_io_kind = is_irq_ack || is_io_read || is_io_write;
    end

    // Arbitration and qualifier gating
    always_comb begin
        // Grant is taken from the synced pin, so release is seen first
        grant_on = !grant_n_sync && grant_ready;
        mem_ok = grant_on && qualifier_sync;
        // I/O side skips arbitration in I/O mode
        io_ok = (io_mode || grant_on) && qualifier_sync;
    end

    // Command outputs
    logic next_mem_read_n;
    logic next_early_mem_write_n;
    logic next_mem_write_n;
    logic next_io_read_n;
    logic next_early_io_write_n;
    logic next_io_write_n;
    logic next_irq_ack_n;

    always_comb begin
        next_mem_read_n = !(cmd_phase && is_mem_read && mem_ok);
        next_early_mem_write_n =
            !(cmd_phase && is_mem_write && mem_ok);
        // Plain write only once its early write is already out
        next_mem_write_n = !(write_phase && is_mem_write && mem_ok
            && !early_mem_write_n);
        next_io_read_n = !(cmd_phase && is_io_read && io_ok);
        next_early_io_write_n =
            !(cmd_phase && is_io_write && io_ok);
        next_io_write_n = !(write_phase && is_io_write && io_ok
            && !early_io_write_n);
        next_irq_ack_n = !(cmd_phase && is_irq_ack && io_ok);
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            mem_read_n <= `CMD_IDLE;
            early_mem_write_n <= `CMD_IDLE;
            mem_write_n <= `CMD_IDLE;
            io_read_n <= `CMD_IDLE;
            early_io_write_n <= `CMD_IDLE;
            io_write_n <= `CMD_IDLE;
            irq_ack_n <= `CMD_IDLE;
        end else begin
            mem_read_n <= next_mem_read_n;
            early_mem_write_n <= next_early_mem_write_n;
            mem_write_n <= next_mem_write_n;
            io_read_n <= next_io_read_n;
            early_io_write_n <= next_early_io_write_n;
            io_write_n <= next_io_write_n;
            irq_ack_n <= next_irq_ack_n;
        end
    end

    // Driver enables, low while driving
    logic next_mem_cmd_oe_n;
    logic next_io_cmd_oe_n;

    always_comb begin
        // Drop on the first clock the synced grant is seen released, except the I/O enable in I/O mode
        next_mem_cmd_oe_n = !grant_on;
        next_io_cmd_oe_n = !(io_mode || grant_on);
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            mem_cmd_oe_n <= `OE_OFF;
            io_cmd_oe_n <= `OE_OFF;
        end else begin
            mem_cmd_oe_n <= next_mem_cmd_oe_n;
            io_cmd_oe_n <= next_io_cmd_oe_n;
        end
    end

    // Control outputs
    logic next_address_strobe;
    logic next_data_enable;
    logic next_xfer_direction;
    logic next_cascade_or_periph_enable;
    logic transfer;
    logic periph_xcvr_enable_n;
    logic cascade_addr_enable;

    always_comb begin
        transfer = cmd_phase && (is_io_kind || is_mem_read || is_mem_write);
        // Strobe also marks halt cycles so status can be latched
        next_address_strobe = strobe_phase;
        // Transceiver of the I/O bus moves to the shared pin in I/O mode
        if (is_io_kind && io_mode) begin
            next_data_enable = 1'b0;
            periph_xcvr_enable_n = !(transfer && io_ok);
        end else begin
            next_data_enable =
                transfer && (is_io_kind ? io_ok : mem_ok);
            periph_xcvr_enable_n = 1'b1;
        end
        // Reads turn the transceiver round from the strobe onward
        next_xfer_direction =
            !((strobe_phase || cmd_phase) && is_read_kind);
        // In system mode the cascade address is read out during the address strobe of an acknowledge cycle
        cascade_addr_enable = strobe_phase && is_irq_ack;
        if (io_mode) begin
            next_cascade_or_periph_enable = periph_xcvr_enable_n;
        end else begin
            next_cascade_or_periph_enable = cascade_addr_enable;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            address_strobe <= 1'b0;
            data_enable <= 1'b0;
            xfer_direction <= `DIR_IDLE;
            cascade_or_periph_enable <= 1'b0;
        end else begin
            address_strobe <= next_address_strobe;
            data_enable <= next_data_enable;
            xfer_direction <= next_xfer_direction;
            cascade_or_periph_enable <= next_cascade_or_periph_enable;
        end
    end

endmodule

// *** status_checker_sva.sv ***
// Port-level timing checks for the status command generator
`timescale 1ns/1ps
module status_checker (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic cycle_status_bit0_n,
    input wire logic cycle_status_bit1_n,
    input wire logic cycle_status_bit2_n,
    input wire logic bus_grant_n,
    input wire logic command_qualifier,
    input wire logic bus_mode_strap,
    input wire logic address_strobe,
    input wire logic data_enable,
    input wire logic xfer_direction,
    input wire logic cascade_or_periph_enable,
    input wire logic early_io_write_n,
    input wire logic io_write_n,
    input wire logic io_read_n,
    input wire logic early_mem_write_n,
    input wire logic mem_write_n,
    input wire logic mem_read_n,
    input wire logic irq_ack_n,
    input wire logic mem_cmd_oe_n,
    input wire logic io_cmd_oe_n
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!nrst);
    logic cmd_idle;
    logic passive;
    assign cmd_idle = early_io_write_n & io_write_n & io_read_n
        & early_mem_write_n & mem_write_n & mem_read_n & irq_ack_n;
    assign passive = cycle_status_bit0_n & cycle_status_bit1_n
        & cycle_status_bit2_n;
    sequence early_mem_s;
        $fell(early_mem_write_n);
    endsequence
    sequence early_io_s;
        $fell(early_io_write_n);
    endsequence
    // Sync plus output flop: four passive samples settle the outputs
    passive_idle_a: assert property (passive[*4] |-> cmd_idle)
        else $error("Command active after passive status");
    strobe_pulse_a: assert property (
        $rose(address_strobe) |=> !address_strobe)
        else $error("Address strobe longer than one cycle");
    qual_block_a: assert property (
        (!command_qualifier)[*4] |-> cmd_idle && !data_enable
        && (cascade_or_periph_enable || !bus_mode_strap))
        else $error("Outputs active with qualifier low");
    release_off_a: assert property (
        bus_grant_n[*4] |-> mem_cmd_oe_n && (io_cmd_oe_n || bus_mode_strap))
        else $error("Drivers on after grant released");
    grant_early_a: assert property (
        $fell(bus_grant_n) |-> mem_cmd_oe_n[*6])
        else $error("Drivers on too soon after grant");
    grant_late_a: assert property (
        $fell(bus_grant_n) |-> ##[6:12] (bus_grant_n || !mem_cmd_oe_n))
        else $error("Drivers on too late after grant");
    mem_grant_a: assert property (
        !(mem_read_n && mem_write_n && early_mem_write_n) |-> !mem_cmd_oe_n)
        else $error("Memory command without drivers");
    io_free_a: assert property (
        bus_mode_strap[*6] |-> !io_cmd_oe_n)
        else $error("I/O drivers off in I/O mode");
    read_dir_a: assert property (
        !(mem_read_n && io_read_n && irq_ack_n) |-> !xfer_direction)
        else $error("Direction high during read");
    write_dir_a: assert property (
        !(mem_write_n && io_write_n) |-> xfer_direction)
        else $error("Direction low during write");
    early_mem_a: assert property (
        early_mem_s |-> mem_write_n ##1 !mem_write_n)
        else $error("Early memory write not one cycle ahead");
    early_io_a: assert property (
        early_io_s |-> io_write_n ##1 !io_write_n)
        else $error("Early I/O write not one cycle ahead");
    den_cmd_a: assert property (
        !mem_read_n || !mem_write_n |-> data_enable)
        else $error("Data enable off during memory command");
endmodule

bind status_command_generator status_checker chk (.clk_sys, .nrst,
    .cycle_status_bit0_n, .cycle_status_bit1_n, .cycle_status_bit2_n,
    .bus_grant_n, .command_qualifier, .bus_mode_strap, .address_strobe,
    .data_enable, .xfer_direction, .cascade_or_periph_enable,
    .early_io_write_n, .io_write_n, .io_read_n, .early_mem_write_n,
    .mem_write_n, .mem_read_n, .irq_ack_n, .mem_cmd_oe_n, .io_cmd_oe_n);

// *** host_side_model.sv ***
// Processor status driver, bus arbiter and mode strap stand-in
`timescale 1ns/1ps
module host_side_model (
    input wire logic [2:0] code,
    input wire logic busy,
    input wire logic grant,
    input wire logic io_mode,
    output logic cycle_status_bit0_n,
    output logic cycle_status_bit1_n,
    output logic cycle_status_bit2_n,
    output logic bus_grant_n,
    output logic bus_mode_strap
);
    // Status pins have pull-ups, so an idle host reads passive
    assign {cycle_status_bit2_n, cycle_status_bit1_n,
        cycle_status_bit0_n} = busy ? code : 3'h7;
    assign bus_grant_n = !grant;
    assign bus_mode_strap = io_mode;
endmodule

// *** status_command_generator_tb.sv ***
// Self-checking bench for the status command generator
`timescale 1ns/1ps
module status_command_generator_tb;
    logic clk_sys, nrst, command_qualifier, busy, grant, io_mode;
    logic [2:0] code;
    logic cycle_status_bit0_n, cycle_status_bit1_n, cycle_status_bit2_n;
    logic bus_grant_n, bus_mode_strap, address_strobe, data_enable;
    logic xfer_direction, cascade_or_periph_enable, early_io_write_n;
    logic io_write_n, io_read_n, early_mem_write_n, mem_write_n;
    logic mem_read_n, irq_ack_n, mem_cmd_oe_n, io_cmd_oe_n;
    int err_count, samples_checked;

    host_side_model host (.code, .busy, .grant, .io_mode,
        .cycle_status_bit0_n, .cycle_status_bit1_n, .cycle_status_bit2_n,
        .bus_grant_n, .bus_mode_strap);
    status_command_generator dut (.clk_sys, .nrst, .cycle_status_bit0_n,
        .cycle_status_bit1_n, .cycle_status_bit2_n, .bus_grant_n,
        .command_qualifier, .bus_mode_strap, .address_strobe, .data_enable,
        .xfer_direction, .cascade_or_periph_enable, .early_io_write_n,
        .io_write_n, .io_read_n, .early_mem_write_n, .mem_write_n,
        .mem_read_n, .irq_ack_n, .mem_cmd_oe_n, .io_cmd_oe_n);

    initial begin
        clk_sys = 0;
        forever #10 clk_sys = ~clk_sys;
    end

    task report_and_stop;
        $display("Checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task chk(input logic seen, input logic exp);
        samples_checked++;
        if (seen !== exp) begin
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
            err_count++;
        end
    endtask

    // Inputs move 1 ns after the edge so sampling never races
    task tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    task do_reset(input logic m);
        nrst = 0;
        io_mode = m;
        grant = 0;
        busy = 0;
        command_qualifier = 1;
        tick(20);
        nrst = 1;
        tick(8);
    endtask

    task grant_test;
        int n;
        grant = 1;
        tick(1);
        n = 0;
        while (mem_cmd_oe_n !== 1'b0 && n < 20) begin
            tick(1);
            n++;
        end
        chk(n * 20 >= 110 && n * 20 <= 250, 1'b1);
        grant = 0;
        tick(4);
        chk(mem_cmd_oe_n, 1'b1);
        if (n == 20) begin
            err_count++;
            report_and_stop();
        end
    endtask

    // Expected levels come from the decode table, mode, grant, qualifier
    task run_cycle(input logic [2:0] c);
        int n;
        logic act, mem, ok;
        mem = c[2];
        ok = mem ? grant : (grant | io_mode);
        act = command_qualifier & ok & (c != 3'h3);
        code = c;
        busy = 1;
        n = 0;
        while (address_strobe !== 1'b1 && n < 10) begin
            tick(1);
            n++;
        end
        if (n == 10) begin
            err_count++;
            report_and_stop();
        end
        chk(xfer_direction, !(c inside {0, 1, 4, 5}));
        if (command_qualifier)
            chk(cascade_or_periph_enable, io_mode | (c == 0));
        tick(2);
        chk(mem_read_n, !(act & mem & !c[1]));
        chk(mem_write_n, !(act & c == 6));
        chk(early_mem_write_n, !(act & c == 6));
        chk(io_read_n, !(act & c == 1));
        chk(io_write_n, !(act & c == 2));
        chk(early_io_write_n, !(act & c == 2));
        chk(irq_ack_n, !(act & c == 0));
        chk(data_enable, act & (mem | !io_mode));
        if (io_mode)
            chk(cascade_or_periph_enable, !(act & !mem));
        chk(mem_cmd_oe_n, !grant);
        chk(io_cmd_oe_n, !(grant | io_mode));
        busy = 0;
        tick(4);
        chk(mem_read_n & mem_write_n & io_read_n & io_write_n & irq_ack_n
            & early_mem_write_n & early_io_write_n, 1'b1);
        chk(data_enable, 1'b0);
        chk(xfer_direction, 1'b1);
        tick(1);
    endtask

    initial begin
        int m, k, i;
        nrst = 0;
        code = 3'h7;
        busy = 0;
        grant = 0;
        io_mode = 0;
        command_qualifier = 1;
        err_count = 0;
        samples_checked = 0;
        void'($urandom(92));
        for (m = 0; m < 2; m++) begin
            do_reset(m[0]);
            grant_test();
            for (k = 0; k < 3; k++) begin
                grant = (k != 1);
                tick(10);
                for (i = 0; i < 7; i++) begin
                    if (k == 2)
                        command_qualifier = 1'($urandom % 2);
                    tick(4);
                    run_cycle(i[2:0]);
                end
                command_qualifier = 1;
                $display("Test mode %0d pass %0d done", m, k);
            end
        end
        report_and_stop();
    end
endmodule
